// [src/ccu_top.sv]
// Clock calendar unit with alarm, drift trim and Avalon-MM registers
`include "ccu_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ccu_top
  import ccu_pkg::*;
(
  // Clock and resets
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Timebase source
  input  wire logic        src_clk_in,
  // Pin and event
  output logic             pin_level,
  output logic             pin_drive,
  output logic             alarm_event
);

  localparam int SEC_TICKS = `CCU_SRC_HZ;
  localparam logic [16:0] PRE_LAST = 17'(SEC_TICKS - 1);
  localparam logic [16:0] PRE_HALF = 17'(SEC_TICKS / 2);
  localparam logic [16:0] PRE_RIP  = 17'(SEC_TICKS - `CCU_RIPPLE_WIN);

  localparam ccu_state_t ST_RST = '{day: `CCU_RST_DAY, mon: `CCU_RST_MON,
                                    ul: CCU_UL_IDLE, default: '0};

  ccu_state_t s_r;
  ccu_state_t s_nxt;

  // BCD step: carry flag and next digit pair
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) return {1'b1, first};
    if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  // Leap year within 2000-2099: BCD year divisible by four
  function automatic logic is_leap(input logic [7:0] y);
    if (!y[4]) return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction

  // Last day of month in BCD
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m)
      `CCU_FEB: return is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Bus handshake, timebase, trim and alarm terms
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic src_rise;
  logic ripple;
  logic half;
  logic match;
  logic fire;
  logic [7:0] wb;
  logic [16:0] trim_load;

  assign req      = avs_read | avs_write;
  assign acc      = req & s_r.served;
  assign wr_acc   = acc & avs_write & avs_byteenable[0];
  assign rd_acc   = acc & avs_read;
  assign wb       = avs_writedata[7:0];
  assign src_rise = src_clk_in & ~s_r.src_d;
  assign half     = $signed(s_r.pre) >= $signed(PRE_HALF);
  assign ripple   = s_r.cal_on & ($signed(s_r.pre) >= $signed(PRE_RIP));
  assign trim_load = {{7{s_r.trim[7]}}, s_r.trim, 2'b00};

  // Masked compare of current time against alarm fields
  always_comb begin
    logic m_s1;
    logic m_s;
    logic m_m1;
    logic m_m;
    logic m_h;
    logic m_w;
    logic m_d;
    logic m_mo;
    m_s1 = s_r.sec[3:0] == s_r.asec[3:0];
    m_s  = s_r.sec == s_r.asec;
    m_m1 = s_r.min[3:0] == s_r.amin[3:0];
    m_m  = s_r.min == s_r.amin;
    m_h  = s_r.hour == s_r.ahour;
    m_w  = s_r.wday == s_r.awday;
    m_d  = s_r.day == s_r.aday;
    m_mo = s_r.mon == s_r.amon;
    case (s_r.alarm_interval_mask)
      4'h0: match = s_r.due_half | s_r.due_sec;
      4'h1: match = s_r.due_sec;
      4'h2: match = s_r.due_sec & m_s1;
      4'h3: match = s_r.due_sec & m_s;
      4'h4: match = s_r.due_sec & m_s & m_m1;
      4'h5: match = s_r.due_sec & m_s & m_m;
      4'h6: match = s_r.due_sec & m_s & m_m & m_h;
      4'h7: match = s_r.due_sec & m_s & m_m & m_h & m_w;
      4'h8: match = s_r.due_sec & m_s & m_m & m_h & m_d;
      4'h9: match = s_r.due_sec & m_s & m_m & m_h & m_d & m_mo;
      default: match = 1'b0;
    endcase
  end

  assign fire = s_r.arm & match;

  // Next state: timebase, calendar, alarm, bus
  always_comb begin
    logic [8:0] st;
    logic       cy;
    s_nxt = s_r;
    st = '0;
    cy = 1'b0;
    if (soft_rst) begin
      s_nxt = ST_RST;
      s_nxt.cal_on = s_r.cal_on;
      s_nxt.unlock = s_r.unlock;
      s_nxt.oe     = s_r.oe;
      s_nxt.vptr   = s_r.vptr;
    end
    s_nxt.src_d       = src_clk_in;
    s_nxt.served      = req & ~s_r.served;
    s_nxt.alarm_pulse = 1'b0;
    s_nxt.due_half    = 1'b0;
    s_nxt.due_sec     = 1'b0;

    // Prescaler and calendar advance
    if (s_r.cal_on && src_rise && !soft_rst) begin
      if (s_r.pre == PRE_LAST) begin
        s_nxt.pre = '0;
        s_nxt.due_sec = 1'b1;
        st = bcd_step(s_r.sec, `CCU_LAST_SEC, 8'h00);
        s_nxt.sec = st[7:0];
        cy = st[8];
        if (cy) begin
          s_nxt.pre = trim_load;
          st = bcd_step(s_r.min, `CCU_LAST_SEC, 8'h00);
          s_nxt.min = st[7:0];
          cy = st[8];
        end
        if (cy) begin
          st = bcd_step(s_r.hour, `CCU_LAST_HOUR, 8'h00);
          s_nxt.hour = st[7:0];
          cy = st[8];
        end
        if (cy) begin
          st = bcd_step(s_r.wday, `CCU_LAST_WDAY, 8'h00);
          s_nxt.wday = st[7:0];
          st = bcd_step(s_r.day, last_day(s_r.mon, s_r.year), `CCU_FIRST_DAY);
          s_nxt.day = st[7:0];
          cy = st[8];
        end
        if (cy) begin
          st = bcd_step(s_r.mon, `CCU_LAST_MON, `CCU_FIRST_DAY);
          s_nxt.mon = st[7:0];
          cy = st[8];
        end
        if (cy) begin
          st = bcd_step(s_r.year, `CCU_LAST_YEAR, 8'h00);
          s_nxt.year = st[7:0];
        end
      end else begin
        s_nxt.pre = s_r.pre + 17'h1;
        s_nxt.due_half = (s_r.pre + 17'h1) == PRE_HALF;
      end
    end

    // Alarm pin level holds until the next half-second step
    if (s_r.due_half || s_r.due_sec) s_nxt.alarm_pin = 1'b0;

    // Alarm event: repeat count and auto disarm
    if (fire) begin
      s_nxt.alarm_pulse = 1'b1;
      s_nxt.alarm_pin = 1'b1;
      if (s_r.rpt != 8'h00) s_nxt.rpt = s_r.rpt - 8'h01;
      else if (s_r.chime) s_nxt.rpt = `CCU_RPT_MAX;
      else s_nxt.arm = 1'b0;
    end

    // Read data is latched in the wait cycle
    case (avs_address)
      `CCU_A_CFG: s_nxt.rdata = {24'h0, s_r.cal_on, 1'b0, s_r.unlock, ripple, half,
                                 s_r.oe, s_r.vptr};
      `CCU_A_TRIM: s_nxt.rdata = {24'h0, s_r.trim};
      `CCU_A_PAD: s_nxt.rdata = {29'h0, s_r.pinsel, 1'b0};
      `CCU_A_ACFG: s_nxt.rdata = {24'h0, s_r.arm, s_r.chime, s_r.alarm_interval_mask, s_r.aptr};
      `CCU_A_RPT: s_nxt.rdata = {24'h0, s_r.rpt};
      `CCU_A_VHIGH: begin
        case (s_r.vptr)
          2'h0: s_nxt.rdata = {24'h0, s_r.min};
          2'h1: s_nxt.rdata = {24'h0, s_r.wday};
          2'h2: s_nxt.rdata = {24'h0, s_r.mon};
          default: s_nxt.rdata = '0;
        endcase
      end
      `CCU_A_VLOW: begin
        case (s_r.vptr)
          2'h0: s_nxt.rdata = {24'h0, s_r.sec};
          2'h1: s_nxt.rdata = {24'h0, s_r.hour};
          2'h2: s_nxt.rdata = {24'h0, s_r.day};
          default: s_nxt.rdata = {24'h0, s_r.year};
        endcase
      end
      `CCU_A_AHIGH: begin
        case (s_r.aptr)
          2'h0: s_nxt.rdata = {24'h0, s_r.amin};
          2'h1: s_nxt.rdata = {24'h0, s_r.awday};
          2'h2: s_nxt.rdata = {24'h0, s_r.amon};
          default: s_nxt.rdata = '0;
        endcase
      end
      `CCU_A_ALOW: begin
        case (s_r.aptr)
          2'h0: s_nxt.rdata = {24'h0, s_r.asec};
          2'h1: s_nxt.rdata = {24'h0, s_r.ahour};
          2'h2: s_nxt.rdata = {24'h0, s_r.aday};
          default: s_nxt.rdata = '0;
        endcase
      end
      default: s_nxt.rdata = '0;
    endcase
    if (!req || s_r.served) s_nxt.rdata = s_r.rdata;

    // Pointer walk on high window access
    if (acc && avs_address == `CCU_A_VHIGH && s_r.vptr != 2'h0)
      s_nxt.vptr = s_r.vptr - 2'h1;
    if (acc && avs_address == `CCU_A_AHIGH && s_r.aptr != 2'h0)
      s_nxt.aptr = s_r.aptr - 2'h1;

    // Register writes, taken at the accepting edge
    if (wr_acc) begin
      s_nxt.ul = CCU_UL_IDLE;
      case (avs_address)
        `CCU_A_KEY: begin
          if (s_r.ul == CCU_UL_IDLE && wb == `CCU_KEY1) s_nxt.ul = CCU_UL_GOT1;
          else if (s_r.ul == CCU_UL_GOT1 && wb == `CCU_KEY2) s_nxt.ul = CCU_UL_GOT2;
          else s_nxt.ul = CCU_UL_IDLE;
        end
        `CCU_A_CFG: begin
          if (s_r.unlock) s_nxt.cal_on = wb[`CCU_B_ON];
          if (s_r.ul == CCU_UL_GOT2) s_nxt.unlock = wb[`CCU_B_UNLOCK];
          s_nxt.oe = wb[`CCU_B_OE];
          s_nxt.vptr = wb[1:0];
        end
        `CCU_A_TRIM: s_nxt.trim = wb;
        `CCU_A_PAD: s_nxt.pinsel = wb[`CCU_B_SEL_HI:`CCU_B_SEL_LO];
        `CCU_A_ACFG: begin
          s_nxt.arm = wb[`CCU_B_ARM];
          s_nxt.chime = wb[`CCU_B_CHIME];
          s_nxt.alarm_interval_mask = wb[`CCU_B_MASK_HI:`CCU_B_MASK_LO];
          s_nxt.aptr = wb[1:0];
        end
        `CCU_A_RPT: s_nxt.rpt = wb;
        `CCU_A_VHIGH: begin
          if (s_r.unlock) begin
            case (s_r.vptr)
              2'h0: s_nxt.min = wb & `CCU_M_SEC;
              2'h1: s_nxt.wday = wb & `CCU_M_WDAY;
              2'h2: s_nxt.mon = wb & `CCU_M_MON;
              default: s_nxt.vptr = s_nxt.vptr;
            endcase
          end
        end
        `CCU_A_VLOW: begin
          if (s_r.unlock) begin
            case (s_r.vptr)
              2'h0: begin
                s_nxt.sec = wb & `CCU_M_SEC;
                s_nxt.pre = '0;
              end
              2'h1: s_nxt.hour = wb & `CCU_M_HOUR;
              2'h2: s_nxt.day = wb & `CCU_M_HOUR;
              default: s_nxt.year = wb & `CCU_M_YEAR;
            endcase
          end
        end
        `CCU_A_AHIGH: begin
          case (s_r.aptr)
            2'h0: s_nxt.amin = wb & `CCU_M_SEC;
            2'h1: s_nxt.awday = wb & `CCU_M_WDAY;
            2'h2: s_nxt.amon = wb & `CCU_M_MON;
            default: s_nxt.aptr = s_nxt.aptr;
          endcase
        end
        `CCU_A_ALOW: begin
          case (s_r.aptr)
            2'h0: s_nxt.asec = wb & `CCU_M_SEC;
            2'h1: s_nxt.ahour = wb & `CCU_M_HOUR;
            2'h2: s_nxt.aday = wb & `CCU_M_HOUR;
            default: s_nxt.aptr = s_nxt.aptr;
          endcase
        end
        default: s_nxt.ul = CCU_UL_IDLE;
      endcase
    end

    // Pin source mux
    case (s_r.pinsel)
      `CCU_SEL_SOURCE: s_nxt.pin = s_r.src_d;
      `CCU_SEL_SECONDS: s_nxt.pin = half;
      `CCU_SEL_ALARM: s_nxt.pin = s_r.alarm_pin;
      default: s_nxt.pin = 1'b0;
    endcase
    s_nxt.pin = s_nxt.pin & s_r.oe;
  end

  // State register, loaded with ST_RST by rst; soft_rst also reloads reset values, except the config fields, through s_nxt
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign avs_waitrequest = req & ~s_r.served;
  assign avs_readdata    = s_r.rdata;
  assign pin_level       = s_r.pin;
  assign pin_drive       = s_r.oe;
  assign alarm_event     = s_r.alarm_pulse;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_win_lock;
    wr_acc && avs_address == `CCU_A_VLOW && !s_r.unlock && s_r.vptr == 2'h3
      |=> $stable(s_r.year);
  endproperty
  a_win_lock: assert property (p_win_lock) else $error("locked window write landed");

  property p_on_lock;
    wr_acc && avs_address == `CCU_A_CFG && !s_r.unlock && !soft_rst |=> $stable(s_r.cal_on);
  endproperty
  a_on_lock: assert property (p_on_lock) else $error("on bit changed while locked");

  property p_unlock_seq;
    !(wr_acc && avs_address == `CCU_A_CFG && s_r.ul == CCU_UL_GOT2) |=> $stable(s_r.unlock);
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock moved without sequence");

  property p_vptr;
    acc && avs_address == `CCU_A_VHIGH && !wr_acc
      |=> s_r.vptr == (($past(s_r.vptr) == 2'h0) ? 2'h0 : $past(s_r.vptr) - 2'h1);
  endproperty
  a_vptr: assert property (p_vptr) else $error("value pointer walk wrong");

  property p_aptr;
    acc && avs_address == `CCU_A_AHIGH && !wr_acc
      |=> s_r.aptr == (($past(s_r.aptr) == 2'h0) ? 2'h0 : $past(s_r.aptr) - 2'h1);
  endproperty
  a_aptr: assert property (p_aptr) else $error("alarm pointer walk wrong");

  property p_half_clr;
    wr_acc && avs_address == `CCU_A_VLOW && s_r.unlock && s_r.vptr == 2'h0 |=> !half;
  endproperty
  a_half_clr: assert property (p_half_clr) else $error("half phase not cleared");

  property p_rpt;
    fire && !(wr_acc && avs_address == `CCU_A_RPT) && !soft_rst
      |=> s_r.rpt == (($past(s_r.rpt) != 8'h00) ? $past(s_r.rpt) - 8'h01 :
                      ($past(s_r.chime) ? `CCU_RPT_MAX : 8'h00));
  endproperty
  a_rpt: assert property (p_rpt) else $error("repeat count step wrong");

  property p_disarm;
    fire && s_r.rpt == 8'h00 && !s_r.chime && !(wr_acc && avs_address == `CCU_A_ACFG)
      && !soft_rst |=> !s_r.arm;
  endproperty
  a_disarm: assert property (p_disarm) else $error("alarm not disarmed");

  property p_pin_off;
    !s_r.oe |=> !pin_level;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

  property p_halt;
    !s_r.cal_on && !wr_acc && !soft_rst |=> $stable(s_r.sec) && $stable(s_r.pre);
  endproperty
  a_halt: assert property (p_halt) else $error("calendar moved while off");

  property p_event;
    s_r.arm && ((s_r.due_sec && s_r.alarm_interval_mask <= 4'h1) || (s_r.due_half && s_r.alarm_interval_mask == 4'h0))
      |=> alarm_event ##1 !alarm_event;
  endproperty
  a_event: assert property (p_event) else $error("alarm pulse wrong");

  property p_wait;
    req && avs_waitrequest && $stable(avs_address) |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait longer than one cycle");

  c_event: cover property (alarm_event);
  c_unlock: cover property (!s_r.unlock ##1 s_r.unlock);
  c_wrap: cover property (fire && s_r.rpt == 8'h00 && s_r.chime);
  c_minute: cover property (s_r.due_sec && s_r.sec == 8'h00);

endmodule // ccu_top

`default_nettype wire

// [src/ccu_params.svh]
// Offsets, field positions, reset values and timing figures of the clock calendar unit
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// Register byte addresses (one aligned word each)
`define CCU_ADDR_W        6
`define CCU_A_CFG         6'h00
`define CCU_A_TRIM        6'h04
`define CCU_A_PAD         6'h08
`define CCU_A_ACFG        6'h0C
`define CCU_A_RPT         6'h10
`define CCU_A_VHIGH       6'h14
`define CCU_A_VLOW        6'h18
`define CCU_A_AHIGH       6'h1C
`define CCU_A_ALOW        6'h20
`define CCU_A_KEY         6'h24

// Unlock keys
`define CCU_KEY1          8'h55
`define CCU_KEY2          8'hAA

// Calendar configuration fields
`define CCU_B_ON          7
`define CCU_B_UNLOCK      5
`define CCU_B_RIPPLE      4
`define CCU_B_HALF        3
`define CCU_B_OE          2
// Pin source field
`define CCU_B_SEL_HI      2
`define CCU_B_SEL_LO      1
// Alarm configuration fields
`define CCU_B_ARM         7
`define CCU_B_CHIME       6
`define CCU_B_MASK_HI     5
`define CCU_B_MASK_LO     2

// Pin source codes
`define CCU_SEL_ALARM     2'h0
`define CCU_SEL_SECONDS   2'h1
`define CCU_SEL_SOURCE    2'h2

// Field write masks (reserved bits read zero)
`define CCU_M_SEC         8'h7F
`define CCU_M_HOUR        8'h3F
`define CCU_M_WDAY        8'h07
`define CCU_M_MON         8'h1F
`define CCU_M_YEAR        8'hFF

// BCD limits
`define CCU_LAST_SEC      8'h59
`define CCU_LAST_HOUR     8'h23
`define CCU_LAST_WDAY     8'h06
`define CCU_LAST_MON      8'h12
`define CCU_LAST_YEAR     8'h99
`define CCU_FEB           8'h02
`define CCU_FIRST_DAY     8'h01
`define CCU_RST_DAY       8'h01
`define CCU_RST_MON       8'h01
`define CCU_RPT_MAX       8'hFF

// Source timebase: 32.768 kHz, counted in source edges
`define CCU_SRC_HZ        32768
`define CCU_PRE_W         17
`define CCU_RIPPLE_WIN    32

`endif

// [src/ccu_pkg.sv]
// Types of the clock calendar unit
package ccu_pkg;

  // Unlock sequence progress
  typedef enum logic [1:0] {
    CCU_UL_IDLE,
    CCU_UL_GOT1,
    CCU_UL_GOT2
  } ccu_unlock_t;

  // Whole state of the unit
  typedef struct packed {
    logic        cal_on;
    logic        unlock;
    logic        oe;
    logic [1:0]  vptr;
    logic [7:0]  trim;
    logic [1:0]  pinsel;
    logic        arm;
    logic        chime;
    logic [3:0]  alarm_interval_mask;
    logic [1:0]  aptr;
    logic [7:0]  rpt;
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hour;
    logic [7:0]  wday;
    logic [7:0]  day;
    logic [7:0]  mon;
    logic [7:0]  year;
    logic [7:0]  asec;
    logic [7:0]  amin;
    logic [7:0]  ahour;
    logic [7:0]  awday;
    logic [7:0]  aday;
    logic [7:0]  amon;
    logic [16:0] pre;
    logic        src_d;
    logic        due_half;
    logic        due_sec;
    ccu_unlock_t ul;
    logic        served;
    logic [31:0] rdata;
    logic        alarm_pulse;
    logic        alarm_pin;
    logic        pin;
  } ccu_state_t;

endpackage

// [dv/ccu_top_tb.sv]
// Self-checking bench for the clock calendar unit
`include "ccu_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ccu_top_tb;
  import ccu_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        src_clk_in = 1'b0;
  logic        pin_level;
  logic        pin_drive;
  logic        alarm_event;
  int          fail_count = 0;
  int          total_checks = 0;
  int          ev_cnt = 0;
  logic [31:0] q;

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  ccu_top dut_u (
    .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_clk_in(src_clk_in), .pin_level(pin_level), .pin_drive(pin_drive),
    .alarm_event(alarm_event)
  );

  // Count alarm pulses
  always @(posedge ref_clk) begin
    if (alarm_event === 1'b1) ev_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, entered right after a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask

  // Source edges, one per two system cycles
  task automatic toggle(input int n);
    repeat (n) begin
      src_clk_in <= 1'b1;
      @(posedge ref_clk);
      src_clk_in <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #360000;
    fail_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`CCU_A_CFG, 8'h00);
    rd(`CCU_A_RPT, 8'h00);
    bus(1'b1, `CCU_A_TRIM, 8'h81);
    rd(`CCU_A_TRIM, 8'h81);
    // Locked: on and unlock bits refused
    bus(1'b1, `CCU_A_CFG, 8'hA4);
    rd(`CCU_A_CFG, 8'h04);
    bus(1'b1, `CCU_A_VLOW, 8'h12);
    rd(`CCU_A_VLOW, 8'h00);
    rd(6'h3C, 8'h00);
    // Unlock sequence
    bus(1'b1, `CCU_A_KEY, `CCU_KEY1);
    bus(1'b1, `CCU_A_KEY, `CCU_KEY2);
    bus(1'b1, `CCU_A_CFG, 8'h23);
    rd(`CCU_A_CFG, 8'h23);
    // Window mapping and pointer walk
    bus(1'b1, `CCU_A_VLOW, 8'h99);
    rd(`CCU_A_VLOW, 8'h99);
    rd(`CCU_A_VHIGH, 8'h00);
    rd(`CCU_A_CFG, 8'h22);
    bus(1'b1, `CCU_A_VLOW, 8'h28);
    bus(1'b1, `CCU_A_VHIGH, 8'h02);
    rd(`CCU_A_CFG, 8'h21);
    rd(`CCU_A_VLOW, 8'h00);
    rd(`CCU_A_VHIGH, 8'h00);
    rd(`CCU_A_VHIGH, 8'h00);
    rd(`CCU_A_CFG, 8'h20);
    // Soft reset spares the config register
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    @(posedge ref_clk);
    rd(`CCU_A_CFG, 8'h20);
    rd(`CCU_A_TRIM, 8'h00);
    // Alarm windows and pointer
    bus(1'b1, `CCU_A_ACFG, 8'h02);
    bus(1'b1, `CCU_A_ALOW, 8'h15);
    bus(1'b1, `CCU_A_AHIGH, 8'h11);
    rd(`CCU_A_ACFG, 8'h01);
    rd(`CCU_A_ALOW, 8'h00);
    rd(`CCU_A_AHIGH, 8'h00);
    rd(`CCU_A_AHIGH, 8'h00);
    rd(`CCU_A_ACFG, 8'h00);
    bus(1'b1, `CCU_A_ACFG, 8'h02);
    rd(`CCU_A_ALOW, 8'h15);
    rd(`CCU_A_AHIGH, 8'h11);
    // Run: seconds clock on pin, half-second alarm
    bus(1'b1, `CCU_A_PAD, 8'h02);
    bus(1'b1, `CCU_A_CFG, 8'hA4);
    bus(1'b1, `CCU_A_VLOW, 8'h58);
    bus(1'b1, `CCU_A_ACFG, 8'h80);
    toggle(16388);
    chk({31'h0, pin_level}, 32'h1);
    chk({31'h0, pin_drive}, 32'h1);
    chk(ev_cnt, 32'h1);
    rd(`CCU_A_CFG, 8'hAC);
    rd(`CCU_A_ACFG, 8'h00);
    // Chime: count 01 decrements at the whole second
    bus(1'b1, `CCU_A_ACFG, 8'hC0);
    bus(1'b1, `CCU_A_RPT, 8'h01);
    toggle(16348);
    rd(`CCU_A_CFG, 8'hBC);
    toggle(36);
    chk(ev_cnt, 32'h2);
    rd(`CCU_A_RPT, 8'h00);
    rd(`CCU_A_ACFG, 8'hC0);
    rd(`CCU_A_VLOW, 8'h59);
    rd(`CCU_A_CFG, 8'hA4);
    chk({31'h0, pin_level}, 32'h0);
    results();
  end
endmodule // ccu_top_tb

`default_nettype wire
